/* cawd_pkg.sv */
// Constants shared by the counter array PWM and watchdog block
package cawd_pkg;
    // Bus and array sizing
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 8;
    localparam int          NCH        = 6;
    localparam int          WD_CH      = 5;
    // Register byte addresses
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_MODE     = 8'h01;
    localparam logic [7:0]  A_PWMCFG   = 8'h02;
    localparam logic [7:0]  A_CNTL     = 8'h03;
    localparam logic [7:0]  A_CNTH     = 8'h04;
    localparam logic [7:0]  A_CMPL0    = 8'h08;
    localparam logic [7:0]  A_CMPH0    = 8'h09;
    localparam logic [7:0]  A_CHMODE0  = 8'h14;
    // Control register fields
    localparam int          CTL_CF     = 7;
    localparam int          CTL_CR     = 6;
    // Array mode register fields
    localparam int          MD_IDLE_SUSPEND_BIT    = 7;
    localparam int          MD_WATCHDOG_ENABLE_BIT    = 6;
    localparam int          MD_WATCHDOG_LOCK_BIT   = 5;
    localparam int          MD_CPS_LSB = 1;
    localparam int          MD_ECF     = 0;
    // PWM config register fields
    localparam int          CFG_RELOAD_VIEW_SELECT  = 7;
    localparam int          CFG_ECOV   = 6;
    localparam int          CFG_CYCLE_OVERFLOW_FLAG   = 5;
    localparam int          CFG_CL_LSB = 0;
    // Channel mode register fields
    localparam int          CM_PWM16   = 7;
    localparam int          CM_ECOM    = 6;
    localparam int          CM_MAT     = 3;
    localparam int          CM_PWM     = 1;
    // Reset values
    localparam logic        RST_WATCHDOG_ENABLE_BIT   = 1'b1;
    localparam logic [2:0]  RST_CPS    = 3'h0;
    localparam logic [15:0] RST_CNT    = 16'h0000;
    localparam logic [15:0] RST_CMP    = 16'h0000;
    localparam logic [7:0]  RST_MODE   = 8'h00;
    // Counter clock selections and prescale
    localparam logic [2:0]  CPS_DIV12  = 3'h0;
    localparam logic [2:0]  CPS_DIV4   = 3'h1;
    localparam logic [2:0]  CPS_SYS    = 3'h4;
    localparam logic [3:0]  DIV_LAST   = 4'hb;
    localparam logic [1:0]  DIV4_LAST  = 2'h3;
    // Cycle length codes
    localparam logic [1:0]  CL_8       = 2'h0;
    localparam logic [1:0]  CL_9       = 2'h1;
    localparam logic [1:0]  CL_10      = 2'h2;
endpackage : cawd_pkg

/* cawd_top.sv */
// Counter array with 8 to 11 bit and 16 bit PWM channels and channel 5 watchdog
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module cawd_top #(
    parameter int NCH = cawd_pkg::NCH
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [cawd_pkg::ADDR_W-1:0] addr,
    input  wire logic [cawd_pkg::DATA_W-1:0] wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [cawd_pkg::DATA_W-1:0] rdata,
    input  wire logic                        ext_tick,
    input  wire logic                        cpu_idle,
    output logic      [NCH-1:0]              chan_out,
    output logic                             wd_reset
);

    // Mask of the counter bits that make one narrow PWM cycle
    function automatic logic [15:0] cycle_mask(input logic [1:0] cl);
        cycle_mask = (cl == cawd_pkg::CL_8)  ? 16'h00ff :
                     (cl == cawd_pkg::CL_9)  ? 16'h01ff :
                     (cl == cawd_pkg::CL_10) ? 16'h03ff : 16'h07ff;
    endfunction : cycle_mask

    // State
    logic [15:0]    cnt;
    logic [3:0]     div;
    logic           cf;
    logic           cr;
    logic [NCH-1:0] ccf;
    logic           idle_suspend_bit;
    logic           watchdog_enable_bit;
    logic           watchdog_lock_bit;
    logic [2:0]     cps;
    logic           ecf;
    logic           reload_view_select;
    logic           ecov;
    logic           cycle_overflow_flag;
    logic [1:0]     cycle_length_select;
    logic [7:0]     mode [NCH];
    logic [15:0]    cmp  [NCH];
    logic [15:0]    arl  [NCH];

    // Common decode
    wire            wd_en     = watchdog_enable_bit | watchdog_lock_bit;
    wire            wr_ctrl   = wr && addr == cawd_pkg::A_CTRL;
    wire            wr_mode   = wr && addr == cawd_pkg::A_MODE;
    wire            wr_cfg    = wr && addr == cawd_pkg::A_PWMCFG;
    wire            wr_cnt_lo = wr && addr == cawd_pkg::A_CNTL && !wd_en;
    wire            wr_cnt_hi = wr && addr == cawd_pkg::A_CNTH && !wd_en;
    wire [15:0]     mask      = cycle_mask(cycle_length_select);

    // Counter clock select and run control
    wire            pre_tick  = (cps == cawd_pkg::CPS_DIV12) ? (div == cawd_pkg::DIV_LAST) :
                                (cps == cawd_pkg::CPS_DIV4)  ? (div[1:0] == cawd_pkg::DIV4_LAST) :
                                (cps == cawd_pkg::CPS_SYS)   ? 1'b1 : ext_tick;
    wire            run       = cr | wd_en;
    wire            tick      = run && pre_tick && !(idle_suspend_bit && cpu_idle);
    wire [15:0]     next_cnt  = cnt + 16'h0001;
    wire            ovf16     = tick && cnt == 16'hffff;
    wire            ovf_n     = tick && (cnt & mask) == mask;
    wire            ovf_lo    = tick && cnt[7:0] == 8'hff;

    // Watchdog kick and trigger
    wire            wr_kick   = wr && wd_en && addr == cawd_pkg::A_CMPH0 + 8'(2 * cawd_pkg::WD_CH);
    wire [7:0]      kick_val  = cnt[15:8] + cmp[cawd_pkg::WD_CH][7:0];
    wire            wd_expire = wd_en && ovf_lo && cmp[cawd_pkg::WD_CH][15:8] == cnt[15:8];
    wire            wd_force  = wd_en && wr_ctrl && wdata[cawd_pkg::WD_CH];

    // Per-channel decode, compare and output logic
    logic [NCH-1:0] hit;
    logic [NCH-1:0] pwm_on;
    logic [NCH-1:0] narrow;
    logic [NCH-1:0] fall;
    logic [NCH-1:0] reload;
    logic [NCH-1:0] wr_lo;
    logic [NCH-1:0] wr_hi;
    logic [NCH-1:0] wr_cm;
    logic [NCH-1:0] ev_set;
    logic [7:0]     emode [NCH];
    logic [15:0]    rl_val [NCH];
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            localparam logic [7:0] ALO = cawd_pkg::A_CMPL0 + 8'(2 * g);
            localparam logic [7:0] AHI = cawd_pkg::A_CMPH0 + 8'(2 * g);
            localparam logic [7:0] AMD = cawd_pkg::A_CHMODE0 + 8'(g);
            localparam bit         IS_WD = (g == cawd_pkg::WD_CH);
            wire [15:0] cur_cmp;
            // Channel 5 runs as a software timer under the watchdog
            assign emode[g]  = (IS_WD && wd_en) ? 8'h48 : mode[g];
            assign wr_lo[g]  = wr && addr == ALO;
            assign wr_hi[g]  = wr && addr == AHI;
            assign wr_cm[g]  = wr && addr == AMD && !(IS_WD && wd_en);
            assign pwm_on[g] = emode[g][cawd_pkg::CM_PWM];
            assign narrow[g] = pwm_on[g] && !emode[g][cawd_pkg::CM_PWM16];
            // 8-bit reloads low from high byte; longer lengths use auto-reload
            assign rl_val[g] = (cycle_length_select == cawd_pkg::CL_8) ? {cmp[g][15:8], cmp[g][15:8]} : arl[g];
            assign reload[g] = narrow[g] && ovf_n;
            assign cur_cmp   = reload[g] ? rl_val[g] : cmp[g];
            assign hit[g]    = tick && emode[g][cawd_pkg::CM_ECOM] &&
                               (narrow[g] ? (next_cnt & mask) == (cur_cmp & mask)
                                          : next_cnt == cmp[g]);
            assign fall[g]   = narrow[g] ? ovf_n : ovf16;
            assign ev_set[g] = hit[g] && emode[g][cawd_pkg::CM_MAT];
        end
    endgenerate

    // Read data selection
    logic [7:0] rmux;
    always_comb
    begin
        rmux = 8'h00;
        if (addr == cawd_pkg::A_CTRL)
            rmux = {cf, cr, 6'(ccf)};
        else if (addr == cawd_pkg::A_MODE)
            rmux = {idle_suspend_bit, watchdog_enable_bit, watchdog_lock_bit, 1'b0, cps, ecf};
        else if (addr == cawd_pkg::A_PWMCFG)
            rmux = {reload_view_select, ecov, cycle_overflow_flag, 3'h0, cycle_length_select};
        else if (addr == cawd_pkg::A_CNTL)
            rmux = cnt[7:0];
        else if (addr == cawd_pkg::A_CNTH)
            rmux = cnt[15:8];
        for (int i = 0; i < NCH; i++)
        begin
            if (addr == cawd_pkg::A_CMPL0 + 8'(2 * i))
                rmux = reload_view_select ? arl[i][7:0] : cmp[i][7:0];
            if (addr == cawd_pkg::A_CMPH0 + 8'(2 * i))
                rmux = reload_view_select ? arl[i][15:8] : cmp[i][15:8];
            if (addr == cawd_pkg::A_CHMODE0 + 8'(i))
                rmux = mode[i];
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= 8'h00;
        else
            rdata <= rd ? rmux : 8'h00;
    end

    // Prescaler and counter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            div <= 4'h0;
            cnt <= cawd_pkg::RST_CNT;
        end
        else
        begin
            div <= (div == cawd_pkg::DIV_LAST) ? 4'h0 : div + 4'h1;
            cnt <= {wr_cnt_hi ? wdata : (tick ? next_cnt[15:8] : cnt[15:8]),
                    wr_cnt_lo ? wdata : (tick ? next_cnt[7:0] : cnt[7:0])};
        end
    end

    // Control and mode registers; hardware set wins over software clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cf    <= 1'b0;
            cr    <= 1'b0;
            ccf   <= '0;
            idle_suspend_bit  <= 1'b0;
            watchdog_enable_bit  <= cawd_pkg::RST_WATCHDOG_ENABLE_BIT;
            watchdog_lock_bit <= 1'b0;
            cps   <= cawd_pkg::RST_CPS;
            ecf   <= 1'b0;
        end
        else
        begin
            cf  <= (wr_ctrl ? wdata[cawd_pkg::CTL_CF] : cf) | ovf16;
            cr  <= wr_ctrl ? wdata[cawd_pkg::CTL_CR] : cr;
            ccf <= (wr_ctrl ? wdata[NCH-1:0] : ccf) | ev_set;
            if (wr_mode)
            begin
                watchdog_enable_bit  <= wdata[cawd_pkg::MD_WATCHDOG_ENABLE_BIT];
                watchdog_lock_bit <= watchdog_lock_bit | wdata[cawd_pkg::MD_WATCHDOG_LOCK_BIT];
                ecf   <= wdata[cawd_pkg::MD_ECF];
                if (!wd_en)
                begin
                    idle_suspend_bit <= wdata[cawd_pkg::MD_IDLE_SUSPEND_BIT];
                    cps  <= wdata[cawd_pkg::MD_CPS_LSB +: 3];
                end
            end
        end
    end

    // PWM configuration register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reload_view_select <= 1'b0;
            ecov  <= 1'b0;
            cycle_overflow_flag  <= 1'b0;
            cycle_length_select <= cawd_pkg::CL_8;
        end
        else
        begin
            cycle_overflow_flag <= (wr_cfg ? wdata[cawd_pkg::CFG_CYCLE_OVERFLOW_FLAG] : cycle_overflow_flag) | ovf_n;
            if (wr_cfg)
            begin
                reload_view_select <= wdata[cawd_pkg::CFG_RELOAD_VIEW_SELECT];
                ecov  <= wdata[cawd_pkg::CFG_ECOV];
                cycle_length_select <= wdata[cawd_pkg::CFG_CL_LSB +: 2];
            end
        end
    end

    // Channel registers and outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            chan_out <= '0;
            for (int i = 0; i < NCH; i++)
            begin
                mode[i] <= cawd_pkg::RST_MODE;
                cmp[i]  <= cawd_pkg::RST_CMP;
                arl[i]  <= cawd_pkg::RST_CMP;
            end
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (wr_cm[i])
                    mode[i] <= wdata;
                else if (wr_lo[i])
                    mode[i][cawd_pkg::CM_ECOM] <= 1'b0;
                else if (wr_hi[i])
                    mode[i][cawd_pkg::CM_ECOM] <= 1'b1;
                if (wr_lo[i] && reload_view_select)
                    arl[i][7:0] <= wdata;
                if (wr_hi[i] && reload_view_select)
                    arl[i][15:8] <= wdata;
                if (i == cawd_pkg::WD_CH && wr_kick)
                    cmp[i][15:8] <= kick_val;
                else if (wr_hi[i] && !reload_view_select)
                    cmp[i][15:8] <= wdata;
                else if (reload[i])
                    cmp[i][15:8] <= rl_val[i][15:8];
                if (wr_lo[i] && !reload_view_select)
                    cmp[i][7:0] <= wdata;
                else if (reload[i])
                    cmp[i][7:0] <= rl_val[i][7:0];
                // Match rises the output, overflow drops it
                if (!pwm_on[i] || !emode[i][cawd_pkg::CM_ECOM])
                    chan_out[i] <= 1'b0;
                else if (hit[i])
                    chan_out[i] <= 1'b1;
                else if (fall[i])
                    chan_out[i] <= 1'b0;
            end
        end
    end

    // Watchdog reset pulse
    always_ff @(posedge clk)
    begin
        if (reset)
            wd_reset <= 1'b0;
        else
            wd_reset <= wd_expire | wd_force;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_kick;
        wr_kick ##1 1'b1;
    endsequence

    property p_zero_duty;
        (!pwm_on[0] || !emode[0][cawd_pkg::CM_ECOM]) |=> !chan_out[0];
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("output not zero with pwm off");

    property p_kick;
        wr_kick |=> cmp[cawd_pkg::WD_CH][15:8] == $past(kick_val);
    endproperty
    a_kick: assert property (p_kick) else $error("kick byte not loaded with sum");

    property p_force;
        (wr_ctrl && wdata[cawd_pkg::WD_CH] && wd_en) |=> wd_reset;
    endproperty
    a_force: assert property (p_force) else $error("forced watchdog reset missing");

    property p_expire;
        (wd_en && ovf_lo && cmp[cawd_pkg::WD_CH][15:8] == cnt[15:8]) |=> wd_reset ##1 1'b1;
    endproperty
    a_expire: assert property (p_expire) else $error("watchdog timeout reset missing");

    property p_no_cause;
        !(wd_expire || wd_force) |=> !wd_reset;
    endproperty
    a_no_cause: assert property (p_no_cause) else $error("spurious watchdog reset");

    property p_ecom_lo;
        (wr_lo[0] && !wr_cm[0]) |=> !mode[0][cawd_pkg::CM_ECOM];
    endproperty
    a_ecom_lo: assert property (p_ecom_lo) else $error("low byte write kept compare enable");

    property p_ecom_hi;
        wr_hi[0] |=> mode[0][cawd_pkg::CM_ECOM];
    endproperty
    a_ecom_hi: assert property (p_ecom_hi) else $error("high byte write did not set compare enable");

    property p_cnt_locked;
        (wd_en && wr && (addr == cawd_pkg::A_CNTL || addr == cawd_pkg::A_CNTH)) |=>
            cnt == $past(cnt) || cnt == $past(next_cnt);
    endproperty
    a_cnt_locked: assert property (p_cnt_locked) else $error("counter written under watchdog");

    property p_after_reset;
        $past(reset) |-> wd_en && cps == cawd_pkg::CPS_DIV12 && cnt == 16'h0000;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("bad state after reset");

    property p_lock;
        watchdog_lock_bit |=> wd_en [*2];
    endproperty
    a_lock: assert property (p_lock) else $error("locked watchdog disabled");

    property p_cycle_overflow_flag;
        ovf_n |=> cycle_overflow_flag;
    endproperty
    a_cycle_overflow_flag: assert property (p_cycle_overflow_flag) else $error("cycle overflow flag not set");

    property p_rise;
        (hit[0] && pwm_on[0]) |=> chan_out[0];
    endproperty
    a_rise: assert property (p_rise) else $error("match did not raise output");

    property p_kick_hold;
        s_kick |-> !wd_reset || $past(wd_expire || wd_force);
    endproperty
    a_kick_hold: assert property (p_kick_hold) else $error("reset without cause after kick");

endmodule : cawd_top

/* test_cawd_top.sv */
// Self-checking testbench for the counter array PWM and watchdog block
`timescale 1ns/1ps
module test_cawd_top;
    typedef struct {logic [1:0] cl; logic [15:0] cmp; int highs;} cawd_row_type;
    logic                        clk;
    logic                        reset;
    logic [cawd_pkg::ADDR_W-1:0] addr;
    logic [cawd_pkg::DATA_W-1:0] wdata;
    logic                        wr;
    logic                        rd;
    logic [cawd_pkg::DATA_W-1:0] rdata;
    logic                        ext_tick;
    logic                        cpu_idle;
    logic [cawd_pkg::NCH-1:0]    chan_out;
    logic                        wd_reset;
    int                          n_errors;
    int                          checks;
    int                          cyc;
    int                          t0;
    logic [7:0]                  v;
    int                          h;
    cawd_row_type                rows [6];

    cawd_top DUT (
        .clk      (clk),
        .reset    (reset),
        .addr     (addr),
        .wdata    (wdata),
        .wr       (wr),
        .rd       (rd),
        .rdata    (rdata),
        .ext_tick (ext_tick),
        .cpu_idle (cpu_idle),
        .chan_out (chan_out),
        .wd_reset (wd_reset)
    );

    // Clock and cycle stamp
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // Compare and count
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task test_done;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // Bus cycles
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd_reg(a, v);
        chk(what, {8'h00, v}, {8'h00, exp});
    endtask : rd_chk

    task do_reset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t0 = cyc;
    endtask : do_reset

    // Wait for the watchdog pulse, window in cycles since t0
    task wait_wd(input int lo, input int hi);
        while (wd_reset !== 1'b1 && (cyc - t0) < hi)
            @(negedge clk);
        chk("wd reset in window", {15'h0000, (wd_reset === 1'b1) && ((cyc - t0) >= lo)}, 16'h0001);
    endtask : wait_wd

    // High cycles of channel 0 over a span
    task count_high(input int span);
        h = 0;
        repeat (span)
        begin
            @(negedge clk);
            if (chan_out[0] === 1'b1)
                h++;
        end
    endtask : count_high

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge clk);
        n_errors++;
        test_done();
    end

    // Main sequence
    initial
    begin
        reset = 1'b1; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        ext_tick = 1'b0; cpu_idle = 1'b0; n_errors = 0; checks = 0; cyc = 0; t0 = 0;
        rows = '{'{2'h0, 16'h0000, 256}, '{2'h0, 16'hffff, 1}, '{2'h0, 16'h8080, 128},
                 '{2'h1, 16'h0100, 256}, '{2'h2, 16'h03ff, 1}, '{2'h3, 16'h0005, 2043}};
        do_reset();
        // Ordinary cases: one row per cycle length and duty
        wr_reg(cawd_pkg::A_MODE, 8'h00);
        wr_reg(cawd_pkg::A_MODE, 8'h08);
        wr_reg(cawd_pkg::A_CTRL, 8'h40);
        foreach (rows[i])
        begin
            v = (rows[i].cl != cawd_pkg::CL_8) ? {6'h20, rows[i].cl} : 8'h00;
            wr_reg(cawd_pkg::A_PWMCFG, v);
            wr_reg(cawd_pkg::A_CMPL0, rows[i].cmp[7:0]);
            wr_reg(cawd_pkg::A_CMPH0, rows[i].cmp[15:8]);
            wr_reg(cawd_pkg::A_CHMODE0, 8'h4a);
            repeat ((256 << rows[i].cl) + 8) @(posedge clk);
            wr_reg(cawd_pkg::A_CTRL, 8'h40);
            count_high(256 << rows[i].cl);
            chk("pwm high count", 16'(h), 16'(rows[i].highs));
            rd_reg(cawd_pkg::A_CTRL, v);
            chk("match event flag", {15'h0000, v[0]}, 16'h0001);
            wr_reg(cawd_pkg::A_PWMCFG, {6'h20, rows[i].cl});
            rd_reg(cawd_pkg::A_PWMCFG, v);
            while (v[5] !== 1'b1 && (cyc - t0) < 80000)
                rd_reg(cawd_pkg::A_PWMCFG, v);
            wr_reg(cawd_pkg::A_PWMCFG, {6'h20, rows[i].cl});
            repeat ((256 << rows[i].cl) - 16) @(posedge clk);
            rd_reg(cawd_pkg::A_PWMCFG, v);
            chk("cycle flag early", {15'h0000, v[5]}, 16'h0000);
            repeat (24) @(posedge clk);
            rd_reg(cawd_pkg::A_PWMCFG, v);
            chk("cycle flag on time", {15'h0000, v[5]}, 16'h0001);
        end
        $display("test pwm table done");
        // Compare enable off holds output low
        wr_reg(cawd_pkg::A_PWMCFG, 8'h00);
        wr_reg(cawd_pkg::A_CHMODE0, 8'h02);
        @(posedge clk); // Output drops one edge after the mode write
        count_high(300);
        chk("disabled pwm high count", 16'(h), 16'h0000);
        // Wide PWM near counter wrap
        wr_reg(cawd_pkg::A_CTRL, 8'h00);
        wr_reg(cawd_pkg::A_CNTL, 8'he0);
        wr_reg(cawd_pkg::A_CNTH, 8'hff);
        wr_reg(cawd_pkg::A_CMPL0, 8'hf0);
        wr_reg(cawd_pkg::A_CMPH0, 8'hff);
        wr_reg(cawd_pkg::A_CHMODE0, 8'hcb);
        wr_reg(cawd_pkg::A_CTRL, 8'h40);
        count_high(64);
        chk("wide pwm high count", 16'(h), 16'h0010);
        rd_reg(cawd_pkg::A_CTRL, v);
        chk("counter overflow flag", {15'h0000, v[7]}, 16'h0001);
        chk("wide match flag", {15'h0000, v[0]}, 16'h0001);
        // Reload view and compare enable side effects on channel 1
        wr_reg(cawd_pkg::A_CMPL0 + 8'h02, 8'h11);
        rd_chk("ecom after low", cawd_pkg::A_CHMODE0 + 8'h01, 8'h00);
        wr_reg(cawd_pkg::A_CMPH0 + 8'h02, 8'h22);
        rd_chk("ecom after high", cawd_pkg::A_CHMODE0 + 8'h01, 8'h40);
        wr_reg(cawd_pkg::A_PWMCFG, 8'h80);
        wr_reg(cawd_pkg::A_CMPL0 + 8'h02, 8'h33);
        rd_chk("reload view", cawd_pkg::A_CMPL0 + 8'h02, 8'h33);
        wr_reg(cawd_pkg::A_PWMCFG, 8'h00);
        rd_chk("compare view", cawd_pkg::A_CMPL0 + 8'h02, 8'h11);
        rd_chk("unmapped read", 8'h30, 8'h00);
        $display("test pwm awkward cases done");
        // Reset values, offset, kick and blocked writes
        do_reset();
        rd_chk("mode after reset", cawd_pkg::A_MODE, 8'h40);
        rd_chk("control after reset", cawd_pkg::A_CTRL, 8'h00);
        rd_chk("offset after reset", cawd_pkg::A_CMPL0 + 8'h0a, 8'h00);
        wr_reg(cawd_pkg::A_CMPL0 + 8'h0a, 8'h03);
        wr_reg(cawd_pkg::A_CMPH0 + 8'h0a, 8'haa);
        rd_chk("kick byte", cawd_pkg::A_CMPH0 + 8'h0a, 8'h03);
        wr_reg(cawd_pkg::A_MODE, 8'hc8);
        rd_chk("mode frozen", cawd_pkg::A_MODE, 8'h40);
        wr_reg(cawd_pkg::A_CNTH, 8'h55);
        rd_chk("counter write blocked", cawd_pkg::A_CNTH, 8'h00);
        wait_wd(12248, 12318);
        $display("test watchdog kick done");
        // Default timeout, then forced reset
        do_reset();
        wait_wd(3032, 3102);
        do_reset();
        wr_reg(cawd_pkg::A_CTRL, 8'h20);
        t0 = cyc;
        wait_wd(0, 4);
        $display("test watchdog reset causes done");
        // Disable, lock and freeze
        do_reset();
        wr_reg(cawd_pkg::A_MODE, 8'h00);
        rd_chk("mode disabled", cawd_pkg::A_MODE, 8'h00);
        wr_reg(cawd_pkg::A_MODE, 8'h08);
        rd_chk("clock select free", cawd_pkg::A_MODE, 8'h08);
        // Idle suspend pauses a running counter
        wr_reg(cawd_pkg::A_MODE, 8'h88);
        wr_reg(cawd_pkg::A_CTRL, 8'h40);
        cpu_idle <= 1'b1;
        rd_reg(cawd_pkg::A_CNTL, v);
        rd_chk("counter paused in idle", cawd_pkg::A_CNTL, v);
        @(posedge clk);
        cpu_idle <= 1'b0;
        wr_reg(cawd_pkg::A_MODE, 8'h20);
        wr_reg(cawd_pkg::A_MODE, 8'h08);
        rd_chk("locked mode", cawd_pkg::A_MODE, 8'h20);
        wr_reg(cawd_pkg::A_CTRL, 8'h20);
        t0 = cyc;
        wait_wd(0, 4);
        $display("test watchdog lock done");
        test_done();
    end
endmodule : test_cawd_top
